// *** hw/ble_exec_defs.vh ***
// Constants for the byte and bit logic execution unit.
// Assumes inclusion by its bare name from the design file of the unit.
`ifndef BLE_EXEC_DEFS_VH
`define BLE_EXEC_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte addresses on the AXI4-Lite slave
// ----------------------------------------------------------------------------
`define BLE_ADDR_W           8
`define BLE_REG_INSTR        8'h00
`define BLE_REG_ACC          8'h04
`define BLE_REG_FLAGS        8'h08
`define BLE_REG_CTRL         8'h0C
`define BLE_REG_EXEC_STAT    8'h10
`define BLE_REG_FILE_ADDR    8'h14
`define BLE_REG_FILE_DATA    8'h18
`define BLE_REG_PORT_LATCH   8'h1C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define BLE_FLAG_CARRY       0
`define BLE_FLAG_DIGIT       1
`define BLE_FLAG_ZERO        2
`define BLE_CTRL_PSC_TMR     0
`define BLE_STAT_BUSY        0
`define BLE_STAT_SKIP        1
`define BLE_STAT_TWO_CYC     2
`define BLE_STAT_UNSUPP      3
`define BLE_INSTR_RESET      14'h0080
`define BLE_RESP_OKAY        2'h0
`define BLE_RESP_SLVERR      2'h2

// ----------------------------------------------------------------------------
// File register map and opcode patterns
// ----------------------------------------------------------------------------
`define BLE_FILE_TIMER_ADDR  7'h01
`define BLE_FILE_PORT_ADDR   7'h05
`define BLE_OP6_ADD_FILE     6'h07
`define BLE_OP6_AND_FILE     6'h05
`define BLE_OP6_AND_LIT      6'h39
`define BLE_OP5_ADD_LIT      5'h1F
`define BLE_OP4_BIT_CLR      4'h4
`define BLE_OP4_BIT_SET      4'h5
`define BLE_OP4_BIT_TSC      4'h6

`endif

// *** hw/ble_exec.v ***
// Byte and bit logic execution unit with an AXI4-Lite register slave.
// Assumes a single 100 MHz clock, asynchronous active-low reset, and port
// pins that arrive from outside the clock domain.
//
// Summary of operation
// - Read-modify-write of the I/O port reads pin levels, not the latch.
// - Writing back to timer zero count clears prescaler when assigned to timer.
// - A bit test that skips takes two cycles; second is no-op.
// - Literal add puts W plus literal in W, updating carry, digit carry, zero.
// - Bit clear zeroes selected bit of file register; flags unchanged.
// - Bit set forces selected bit of file register to one; flags unchanged.
// - Byte add sums W and file register, updating carry, digit carry, zero.
// - Destination select zero writes W, one writes back the file register.
// - Literal AND puts W AND literal in W; only zero flag updates.
// - Byte AND of W and file register follows destination; only zero flag.
// - Bit test skips next instruction as a no-op when the bit is clear.
// - Bit instructions use three-bit position field and seven-bit address field.
// - Destination select defaults to one, sending results to the file register.
`timescale 1ns/1ps
`include "ble_exec_defs.vh"

module ble_exec
(
    input  wire        mclk_i,
    input  wire        reset_n_i,
    input  wire [7:0]  s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output wire        s_axi_awready_o,
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output wire        s_axi_wready_o,
    output wire [1:0]  s_axi_bresp_o,
    output wire        s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    input  wire [7:0]  s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output wire        s_axi_arready_o,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0]  s_axi_rresp_o,
    output wire        s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    input  wire [7:0]  port_pins_i,
    output wire [7:0]  port_latch_o,
    output wire        prescaler_clear_o,
    output wire        skip_nop_o,
    output wire        busy_o
);

    // ------------------------------------------------------------------------
    // Execution states
    // ------------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_EXEC = 2'h1;
    localparam [1:0] ST_NOP  = 2'h2;

    reg  [1:0]  state_r;
    reg  [13:0] instr_r;
    reg  [7:0]  acc_r;
    reg  [2:0]  flags_r;
    reg         psc_tmr_r;
    reg  [6:0]  file_addr_r;
    reg  [7:0]  port_latch_r;
    reg         last_skip_r;
    reg         last_two_r;
    reg         unsupp_r;
    reg         psc_clr_r;
    reg         skip_nop_r;
    reg  [7:0]  pin_meta_r;
    reg  [7:0]  pin_sync_r;
    reg  [7:0]  file_mem [0:127];

    reg         aw_held_r;
    reg  [7:0]  aw_addr_r;
    reg         w_held_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg         bvalid_r;
    reg  [1:0]  bresp_r;
    reg         arready_r;
    reg         rvalid_r;
    reg  [31:0] rdata_r;
    reg  [1:0]  rresp_r;

    // ------------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------------
    // Two flops on the port pins; only the second is read by logic.
    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pin_meta_r <= 8'h00;
            pin_sync_r <= 8'h00;
        end
        else
        begin
            pin_meta_r <= port_pins_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    // ------------------------------------------------------------------------
    // Instruction decode and datapath
    // ------------------------------------------------------------------------
    wire [6:0] f_addr   = instr_r[6:0];
    wire [2:0] bit_pos  = instr_r[9:7];
    wire       dest_f   = instr_r[7];
    wire [7:0] lit      = instr_r[7:0];
    wire       is_add_f = (instr_r[13:8] == `BLE_OP6_ADD_FILE);
    wire       is_and_f = (instr_r[13:8] == `BLE_OP6_AND_FILE);
    wire       is_and_k = (instr_r[13:8] == `BLE_OP6_AND_LIT);
    wire       is_add_k = (instr_r[13:9] == `BLE_OP5_ADD_LIT);
    wire       is_clr   = (instr_r[13:10] == `BLE_OP4_BIT_CLR);
    wire       is_set   = (instr_r[13:10] == `BLE_OP4_BIT_SET);
    wire       is_tst   = (instr_r[13:10] == `BLE_OP4_BIT_TSC);

    // The I/O port operand is the pin level so a low input pin writes back zero.
    wire [7:0] f_val    = (f_addr == `BLE_FILE_PORT_ADDR) ? pin_sync_r : file_mem[f_addr];
    wire [7:0] add_b    = is_add_k ? lit : f_val;
    wire [8:0] sum9     = {1'b0, acc_r} + {1'b0, add_b};
    wire [4:0] sum_lo   = {1'b0, acc_r[3:0]} + {1'b0, add_b[3:0]};
    wire [7:0] and_b    = is_and_k ? lit : f_val;
    wire [7:0] and_res  = acc_r & and_b;
    wire [7:0] bit_mask = 8'h01 << bit_pos;

    reg  [7:0] res;
    reg        wr_acc;
    reg        wr_file;
    reg  [2:0] flags_nxt;
    reg        skip;
    reg        known;

    // Computes the result, its destination and the new flags of one instruction.
    always @*
    begin
        res       = 8'h00;
        wr_acc    = 1'b0;
        wr_file   = 1'b0;
        flags_nxt = flags_r;
        skip      = 1'b0;
        known     = 1'b1;
        if (is_add_f || is_add_k)
        begin
            res = sum9[7:0];
            flags_nxt[`BLE_FLAG_CARRY] = sum9[8];
            flags_nxt[`BLE_FLAG_DIGIT] = sum_lo[4];
            flags_nxt[`BLE_FLAG_ZERO]  = (sum9[7:0] == 8'h00);
            wr_acc  = is_add_k | ~dest_f;
            wr_file = is_add_f & dest_f;
        end
        else if (is_and_f || is_and_k)
        begin
            res = and_res;
            flags_nxt[`BLE_FLAG_ZERO] = (and_res == 8'h00);
            wr_acc  = is_and_k | ~dest_f;
            wr_file = is_and_f & dest_f;
        end
        else if (is_clr)
        begin
            res     = f_val & ~bit_mask;
            wr_file = 1'b1;
        end
        else if (is_set)
        begin
            res     = f_val | bit_mask;
            wr_file = 1'b1;
        end
        else if (is_tst)
        begin
            skip = ~f_val[bit_pos];
        end
        else
        begin
            known = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite write side
    // ------------------------------------------------------------------------
    // Writes are only performed while no instruction is in flight.
    wire       wr_fire   = aw_held_r & w_held_r & ~bvalid_r & (state_r == ST_IDLE);
    wire       lane0     = w_strb_r[0];
    wire       wr_instr  = wr_fire & (aw_addr_r == `BLE_REG_INSTR) & (w_strb_r[1:0] == 2'h3);
    wire       wr_mapped = (aw_addr_r == `BLE_REG_INSTR) || (aw_addr_r == `BLE_REG_ACC) ||
                           (aw_addr_r == `BLE_REG_FLAGS) || (aw_addr_r == `BLE_REG_CTRL) ||
                           (aw_addr_r == `BLE_REG_EXEC_STAT) || (aw_addr_r == `BLE_REG_FILE_ADDR) ||
                           (aw_addr_r == `BLE_REG_FILE_DATA) || (aw_addr_r == `BLE_REG_PORT_LATCH);
    wire       exec_now  = (state_r == ST_EXEC);
    wire       bus_fwr   = wr_fire & lane0 & (aw_addr_r == `BLE_REG_FILE_DATA);
    wire       exe_fwr   = exec_now & wr_file;
    wire [6:0] fwr_addr  = exe_fwr ? f_addr : file_addr_r;
    wire [7:0] fwr_data  = exe_fwr ? res : w_data_r[7:0];

    // Address and data are taken in either order and held until the write.
    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `BLE_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_i && !aw_held_r)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && !w_held_r)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata_i;
                w_strb_r <= s_axi_wstrb_i;
            end
            if (wr_fire)
            begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_mapped ? `BLE_RESP_OKAY : `BLE_RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready_i)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Execution sequencer and software-visible state
    // ------------------------------------------------------------------------
    // One execute cycle, plus a no-op cycle when the next instruction is skipped.
    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r      <= ST_IDLE;
            instr_r      <= `BLE_INSTR_RESET;
            acc_r        <= 8'h00;
            flags_r      <= 3'h0;
            psc_tmr_r    <= 1'b0;
            file_addr_r  <= 7'h00;
            port_latch_r <= 8'h00;
            last_skip_r  <= 1'b0;
            last_two_r   <= 1'b0;
            unsupp_r     <= 1'b0;
            psc_clr_r    <= 1'b0;
            skip_nop_r   <= 1'b0;
        end
        else
        begin
            psc_clr_r  <= 1'b0;
            skip_nop_r <= 1'b0;
            case (state_r)
                ST_IDLE:
                begin
                    if (wr_instr)
                    begin
                        instr_r <= w_data_r[13:0];
                        state_r <= ST_EXEC;
                    end
                end
                ST_EXEC:
                begin
                    flags_r     <= flags_nxt;
                    last_skip_r <= skip;
                    last_two_r  <= skip;
                    unsupp_r    <= ~known;
                    if (wr_acc)
                        acc_r <= res;
                    if (wr_file && (f_addr == `BLE_FILE_PORT_ADDR))
                        port_latch_r <= res;
                    if (wr_file && (f_addr == `BLE_FILE_TIMER_ADDR) && psc_tmr_r)
                        psc_clr_r <= 1'b1;
                    if (skip)
                    begin
                        skip_nop_r <= 1'b1;
                        state_r    <= ST_NOP;
                    end
                    else
                        state_r <= ST_IDLE;
                end
                ST_NOP:
                begin
                    state_r <= ST_IDLE;
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
            if (wr_fire && lane0)
            begin
                if (aw_addr_r == `BLE_REG_ACC)
                    acc_r <= w_data_r[7:0];
                if (aw_addr_r == `BLE_REG_FLAGS)
                    flags_r <= w_data_r[2:0];
                if (aw_addr_r == `BLE_REG_CTRL)
                    psc_tmr_r <= w_data_r[`BLE_CTRL_PSC_TMR];
                if (aw_addr_r == `BLE_REG_FILE_ADDR)
                    file_addr_r <= w_data_r[6:0];
                if ((aw_addr_r == `BLE_REG_PORT_LATCH) ||
                    ((aw_addr_r == `BLE_REG_FILE_DATA) && (file_addr_r == `BLE_FILE_PORT_ADDR)))
                    port_latch_r <= w_data_r[7:0];
                if ((aw_addr_r == `BLE_REG_FILE_DATA) && (file_addr_r == `BLE_FILE_TIMER_ADDR) && psc_tmr_r)
                    psc_clr_r <= 1'b1;
            end
        end
    end

    // File register array, written by execution or by software.
    always @(posedge mclk_i)
    begin
        if (exe_fwr || bus_fwr)
            file_mem[fwr_addr] <= fwr_data;
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read side
    // ------------------------------------------------------------------------
    wire [7:0] rd_file = (file_addr_r == `BLE_FILE_PORT_ADDR) ? pin_sync_r : file_mem[file_addr_r];
    reg  [31:0] rd_word;
    reg         rd_ok;

    // Selects the word for a read address; unmapped addresses answer SLVERR.
    always @*
    begin
        rd_word = 32'h00000000;
        rd_ok   = 1'b1;
        case (s_axi_araddr_i)
            `BLE_REG_INSTR:      rd_word = {18'h00000, instr_r};
            `BLE_REG_ACC:        rd_word = {24'h000000, acc_r};
            `BLE_REG_FLAGS:      rd_word = {29'h00000000, flags_r};
            `BLE_REG_CTRL:       rd_word = {31'h00000000, psc_tmr_r};
            `BLE_REG_EXEC_STAT:  rd_word = {28'h0000000, unsupp_r, last_two_r, last_skip_r, (state_r != ST_IDLE)};
            `BLE_REG_FILE_ADDR:  rd_word = {25'h0000000, file_addr_r};
            `BLE_REG_FILE_DATA:  rd_word = {24'h000000, rd_file};
            `BLE_REG_PORT_LATCH: rd_word = {24'h000000, port_latch_r};
            default:             rd_ok   = 1'b0;
        endcase
    end

    // Accepts one read at a time and holds the answer until rready.
    always @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= `BLE_RESP_OKAY;
        end
        else if (arready_r && s_axi_arvalid_i)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_word;
            rresp_r   <= rd_ok ? `BLE_RESP_OKAY : `BLE_RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready_i)
        begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Output assignments straight from flops, except the inverted awready/wready flags and busy_o, which ORs the non-idle state with aw_held_r AND w_held_r
    // ------------------------------------------------------------------------
    assign s_axi_awready_o   = ~aw_held_r;
    assign s_axi_wready_o    = ~w_held_r;
    assign s_axi_bvalid_o    = bvalid_r;
    assign s_axi_bresp_o     = bresp_r;
    assign s_axi_arready_o   = arready_r;
    assign s_axi_rvalid_o    = rvalid_r;
    assign s_axi_rdata_o     = rdata_r;
    assign s_axi_rresp_o     = rresp_r;
    assign port_latch_o      = port_latch_r;
    assign prescaler_clear_o = psc_clr_r;
    assign skip_nop_o        = skip_nop_r;
    assign busy_o            = (state_r != ST_IDLE) | aw_held_r & w_held_r;

endmodule // ble_exec

// *** verification/ble_exec_chk.sv ***
// Concurrent checks on the bus handshakes and pulse outputs of ble_exec.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps

module ble_exec_chk
(
    input wire        mclk_i,
    input wire        reset_n_i,
    input wire        s_axi_awready_o,
    input wire        s_axi_wvalid_i,
    input wire        s_axi_awvalid_i,
    input wire        s_axi_wready_o,
    input wire [1:0]  s_axi_bresp_o,
    input wire        s_axi_bvalid_o,
    input wire        s_axi_bready_i,
    input wire        s_axi_arvalid_i,
    input wire        s_axi_arready_o,
    input wire        s_axi_rvalid_o,
    input wire        s_axi_rready_i,
    input wire        prescaler_clear_o,
    input wire        skip_nop_o,
    input wire        busy_o
);
    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    // A write taken on both channels is answered within a few cycles.
    chk_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |-> ##[1:4] s_axi_bvalid_o) else $error("write response missing");
    chk_bresp_once: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("write response repeated");
    chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read answer not one cycle after address");
    chk_rdata_once: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("read answer repeated");
    // The discarded cycle is a single pulse inside the instruction.
    chk_skip_pulse: assert property (skip_nop_o |=> !skip_nop_o)
        else $error("skip cycle longer than one");
    chk_skip_busy: assert property (skip_nop_o |-> busy_o)
        else $error("skip cycle while idle");
    chk_skip_cause: assert property ($rose(skip_nop_o) |-> $past(busy_o))
        else $error("skip without an instruction");
    chk_psc_pulse: assert property (prescaler_clear_o |=> !prescaler_clear_o)
        else $error("prescaler clear longer than one cycle");

    cover property (skip_nop_o);
    cover property (prescaler_clear_o);
    cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
endmodule // ble_exec_chk

bind ble_exec ble_exec_chk i_chk (.mclk_i, .reset_n_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_awvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .prescaler_clear_o, .skip_nop_o, .busy_o);

// *** verification/testbench.sv ***
// Self-checking bench driving the execution unit through its register bus.
// Assumes the register map and opcode fields of the unit's header file.
`timescale 1ns/1ps
`include "ble_exec_defs.vh"

module testbench;
    reg         mclk_i    = 1'b0;
    reg         reset_n_i = 1'b0;
    reg  [7:0]  awaddr = 8'h00, araddr = 8'h00, pins = 8'h00, w, mf, a, k;
    reg  [31:0] wdata = 32'h0;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, sk, d;
    reg  [2:0]  fl, b;
    reg  [33:0] exp_q[$];
    reg  [33:0] e;
    wire        awready, wready, bvalid, arready, rvalid, psc, skip, busy;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [7:0]  latch;
    integer     err_count = 0, comparisons = 0, psc_cnt = 0, i, c;

    always #5 mclk_i = ~mclk_i;

    ble_exec i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .port_pins_i(pins),
        .port_latch_o(latch), .prescaler_clear_o(psc), .skip_nop_o(skip), .busy_o(busy));

    // ------------------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------------------
    // Compares each read answer with the oldest note and counts clear pulses.
    always @(posedge mclk_i)
    begin
        if (rvalid && rready)
        begin
            comparisons = comparisons + 1;
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3FFFFFFFF;
            if ({rresp, rdata} !== e)
            begin
                err_count = err_count + 1;
                $display("Error at %0t: read %h expected %h", $time, {rresp, rdata}, e);
            end
        end
        if (psc === 1'b1)
            psc_cnt = psc_cnt + 1;
    end

    // ------------------------------------------------------------------------
    // Bus and model tasks
    // ------------------------------------------------------------------------
    task print_verdict;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    // A bounded wait that ran out counts as a mismatch and ends the run.
    task hang;
        begin
            err_count = err_count + 1;
            $display("Error at %0t: wait timed out", $time);
            print_verdict;
        end
    endtask

    task wr(input [7:0] ad, input [31:0] dt, input [1:0] er);
        integer n;
        begin
            @(posedge mclk_i);
            awaddr  <= ad;
            wdata   <= dt;
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
            n = 0;
            while (n < 40 && !(bvalid && bready))
            begin
                @(posedge mclk_i);
                if (awready)
                    awvalid <= 1'b0;
                if (wready)
                    wvalid <= 1'b0;
                n = n + 1;
            end
            bready <= 1'b0;
            if (n >= 40)
                hang;
            comparisons = comparisons + 1;
            if (bresp !== er)
            begin
                err_count = err_count + 1;
                $display("Error at %0t: write response %h", $time, bresp);
            end
        end
    endtask

    task rd(input [7:0] ad, input [31:0] dt);
        integer n;
        begin
            exp_q.push_back({`BLE_RESP_OKAY, dt});
            @(posedge mclk_i);
            araddr  <= ad;
            arvalid <= 1'b1;
            rready  <= 1'b1;
            n = 0;
            while (n < 40 && !(rvalid && rready))
            begin
                @(posedge mclk_i);
                if (arready)
                    arvalid <= 1'b0;
                n = n + 1;
            end
            rready <= 1'b0;
            if (n >= 40)
                hang;
        end
    endtask

    // Reference behaviour of one instruction on the bench's own copies.
    task model(input [13:0] o);
        reg [8:0] r;
        begin
            sk = 1'b0;
            r = {1'b0, mf};
            if (o[13:12] == 2'b01)
            begin
                if (o[11:10] == 2'b00)
                    mf[o[9:7]] = 1'b0;
                else if (o[11:10] == 2'b01)
                    mf[o[9:7]] = 1'b1;
                else
                    sk = ~mf[o[9:7]];
            end
            else
            begin
                if (o[13])
                    r = {1'b0, o[7:0]};
                if (o[13:8] == `BLE_OP6_ADD_FILE || o[13:9] == `BLE_OP5_ADD_LIT)
                begin
                    fl[`BLE_FLAG_DIGIT] = ({1'b0, w[3:0]} + {1'b0, r[3:0]}) > 5'h0F;
                    r = {1'b0, w} + r;
                    fl[`BLE_FLAG_CARRY] = r[8];
                end
                else
                    r = {1'b0, w & r[7:0]};
                fl[`BLE_FLAG_ZERO] = (r[7:0] == 8'h00);
                if (o[13] || !o[7])
                    w = r[7:0];
                else
                    mf = r[7:0];
            end
        end
    endtask

    // Runs one instruction, waits for idle, then reads the visible state back.
    task ex(input [13:0] o, input chk_f);
        integer n;
        begin
            model(o);
            wr(`BLE_REG_INSTR, {18'h0, o}, `BLE_RESP_OKAY);
            n = 0;
            @(posedge mclk_i);
            while (n < 20 && busy !== 1'b0)
            begin
                @(posedge mclk_i);
                n = n + 1;
            end
            if (n >= 20)
                hang;
            rd(`BLE_REG_ACC, {24'h0, w});
            rd(`BLE_REG_FLAGS, {29'h0, fl});
            rd(`BLE_REG_EXEC_STAT, {28'h0, 1'b0, sk, sk, 1'b0});
            if (chk_f)
                rd(`BLE_REG_FILE_DATA, {24'h0, mf});
        end
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        c = $urandom(32960);
        w = 8'h00;
        fl = 3'h0;
        repeat (12) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rd(`BLE_REG_INSTR, 32'h0000_0080);
        rd(`BLE_REG_ACC, 32'h0);
        rd(`BLE_REG_FLAGS, 32'h0);
        rd(`BLE_REG_CTRL, 32'h0);
        rd(`BLE_REG_FILE_ADDR, 32'h0);
        wr(8'h40, 32'h5A, `BLE_RESP_SLVERR);
        $display("test reset_and_map done");
        for (i = 0; i < 16; i = i + 1)
        begin
            a = 8'h20 + ($urandom % 96);
            w = $urandom;
            mf = $urandom;
            fl = $urandom;
            k = $urandom;
            b = $urandom;
            d = $urandom;
            wr(`BLE_REG_ACC, {24'h0, w}, `BLE_RESP_OKAY);
            wr(`BLE_REG_FLAGS, {29'h0, fl}, `BLE_RESP_OKAY);
            wr(`BLE_REG_FILE_ADDR, {24'h0, a}, `BLE_RESP_OKAY);
            wr(`BLE_REG_FILE_DATA, {24'h0, mf}, `BLE_RESP_OKAY);
            ex({5'h1F, d, k}, 1'b1);
            ex({6'h07, d, a[6:0]}, 1'b1);
            ex({6'h05, ~d, a[6:0]}, 1'b1);
            ex({6'h39, k}, 1'b1);
            ex({4'h4, b, a[6:0]}, 1'b1);
            ex({4'h6, b, a[6:0]}, 1'b1);
            ex({4'h5, b, a[6:0]}, 1'b1);
            ex({4'h6, b, a[6:0]}, 1'b1);
        end
        $display("test random_ops done");
        pins <= $urandom & 8'h5A;
        wr(`BLE_REG_PORT_LATCH, 32'hFF, `BLE_RESP_OKAY);
        wr(`BLE_REG_FILE_ADDR, {25'h0, `BLE_FILE_PORT_ADDR}, `BLE_RESP_OKAY);
        repeat (4) @(posedge mclk_i);
        mf = pins;
        ex({4'h4, b, `BLE_FILE_PORT_ADDR}, 1'b0);
        rd(`BLE_REG_PORT_LATCH, {24'h0, mf});
        comparisons = comparisons + 1;
        if (latch !== mf)
        begin
            err_count = err_count + 1;
            $display("Error at %0t: port latch %h", $time, latch);
        end
        $display("test port_rmw done");
        wr(`BLE_REG_INSTR, 32'h0, `BLE_RESP_OKAY);
        rd(`BLE_REG_EXEC_STAT, 32'h8);
        mf = $urandom;
        wr(`BLE_REG_FILE_ADDR, {25'h0, `BLE_FILE_TIMER_ADDR}, `BLE_RESP_OKAY);
        wr(`BLE_REG_FILE_DATA, {24'h0, mf}, `BLE_RESP_OKAY);
        wr(`BLE_REG_CTRL, 32'h1, `BLE_RESP_OKAY);
        c = psc_cnt;
        ex({6'h07, 1'b0, `BLE_FILE_TIMER_ADDR}, 1'b1);
        ex({6'h07, 1'b1, `BLE_FILE_TIMER_ADDR}, 1'b1);
        ex({4'h5, b, `BLE_FILE_TIMER_ADDR}, 1'b1);
        wr(`BLE_REG_CTRL, 32'h0, `BLE_RESP_OKAY);
        ex({4'h4, b, `BLE_FILE_TIMER_ADDR}, 1'b1);
        comparisons = comparisons + 1;
        if (psc_cnt !== c + 2)
        begin
            err_count = err_count + 1;
            $display("Error at %0t: prescaler clears %0d", $time, psc_cnt - c);
        end
        $display("test timer_prescaler done");
        print_verdict;
    end
endmodule // testbench
